// >>> hw/pafs_defs.svh
// pafs_defs.svh: addresses, reset values and field positions of the port A function-select block
// assumes: included by its bare name; 16-bit registers on the internal peripheral bus, byte addresses
`ifndef PAFS_DEFS_SVH
`define PAFS_DEFS_SVH

`define PAFS_ADDR_W          28
`define PAFS_DATA_ADDR       28'h5FFFFC2
`define PAFS_DIR_ADDR        28'h5FFFFC6
`define PAFS_LOW_ADDR        28'h5FFFFCA
`define PAFS_HIGH_ADDR       28'h5FFFFCC

`define PAFS_DATA_RST        16'h0000
`define PAFS_DIR_RST         16'h0000
`define PAFS_LOW_RST         16'hFF95
`define PAFS_HIGH_RST        16'h3302

`define PAFS_LOW_WMASK       16'h55FF
`define PAFS_LOW_FIXED1      16'hAA00
`define PAFS_HIGH_WMASK      16'hFFFD
`define PAFS_HIGH_FIXED1     16'h0002

// high register field positions (lsb of each two-bit field)
`define PAFS_P15_LSB         14
`define PAFS_P14_LSB         12
`define PAFS_P13_LSB         10
`define PAFS_P12_LSB         8
`define PAFS_P11_LSB         6
`define PAFS_P10_LSB         4
`define PAFS_P9_LSB          2
`define PAFS_P8_BIT          0
// low register field positions
`define PAFS_P7_BIT          14
`define PAFS_P6_BIT          12
`define PAFS_P5_BIT          10
`define PAFS_P4_BIT          8
`define PAFS_P3_LSB          6
`define PAFS_P2_LSB          4
`define PAFS_P1_LSB          2
`define PAFS_P0_LSB          0

`endif

// >>> hw/pafs_pkg.sv
// pafs_pkg: types of the port A function-select block
// assumes: pafs_defs.svh supplies the numeric constants
package pafs_pkg;

  typedef enum logic [1:0] {
    PAFS_MODE_GPIO = 2'b00,
    PAFS_MODE_ALT1 = 2'b01,
    PAFS_MODE_ALT2 = 2'b10,
    PAFS_MODE_ALT3 = 2'b11
  } pafs_mode_t;

  typedef struct packed {
    logic [15:0] data;
    logic [15:0] dir;
    logic [15:0] low_sel;
    logic [15:0] high_sel;
    logic [15:0] pin_out;
    logic [15:0] pin_oe_n;
    logic [15:0] rdata;
    logic        ack;
    logic [3:0]  ext_int;
    logic [1:0]  dma_req;
    logic [1:0]  tclk;
    logic [1:0]  parity;
    logic [3:0]  tim_cc;
    logic        conversion_trigger_in;
    logic        wait_lvl;
  } pafs_state_t;

  typedef struct packed {
    logic [15:0] s1;
    logic [15:0] s2;
    logic [15:0] s3;
    logic [15:0] lvl;
  } pafs_sync_t;

endpackage

// >>> hw/pafs_pin_sync.sv
// pafs_pin_sync: three-stage synchroniser for pin levels with a two-stage agreement filter
// assumes: inputs are asynchronous to clock_in
`timescale 1ns/1ps
`include "pafs_defs.svh"
module pafs_pin_sync
  import pafs_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        sys_rst_in,
  input  wire logic [15:0] pin_in,
  output logic      [15:0] level_out
);

  pafs_sync_t r;
  pafs_sync_t r_nxt;

  always_comb begin
    r_nxt    = r;
    r_nxt.s1 = pin_in;
    r_nxt.s2 = r.s1;
    r_nxt.s3 = r.s2;
    // a change counts only once stages two and three agree
    r_nxt.lvl = (r.s2 & r.s3) | (r.lvl & (r.s2 ^ r.s3));
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      r <= '0;
    end else begin
      r <= r_nxt;
    end
  end

  assign level_out = r.lvl;

endmodule // pafs_pin_sync

// >>> hw/pafs_pin_function_select.sv
// pafs_pin_function_select: port A mode registers, data/direction registers and pin multiplexer
// assumes: 16-bit internal peripheral bus, one halfword per access, byte lanes by bus_be_in;
// 32-bit accesses are split into two halfword accesses by the bus bridge
`timescale 1ns/1ps
`include "pafs_defs.svh"

// Behaviour
// - pin 15: 00 gpio, 01 ext int 3, 11 dma request 1, 10 reserved, reset 00
// - pin 14: 00 gpio, 01 ext int 2, 11 dma acknowledge 1, reset 11
// - pin 13: 00 gpio, 01 ext int 1, 10 timer clock B, 11 dma request 0
// - pin 12: 00 gpio, 01 ext int 0, 10 timer clock A, 11 dma ack 0, reset 11
// - pin 11: 00 gpio, 01 upper parity io, 10 timer1 capture/compare B, reset 00
// - pin 10: 00 gpio, 01 lower parity io, 10 timer1 capture/compare A, reset 00
// - pin 9: 00 gpio, 01 address hold, 10 conversion trigger, 11 interrupt request out
// - pin 8 mode bit 0 resets 0 for gpio; bit 1 reserved, reads 1
// - pin 7 bit 14: 0 gpio, 1 bus grant acknowledge out, reset 1
// - pin 6 bit 12: 0 gpio, 1 read strobe out, reset 1
// - pin 5 bit 10: 0 gpio, 1 upper store or low byte strobe, reset 1
// - pin 4 bit 8: 0 gpio, 1 lower store or single store strobe, reset 1
// - low register bits 15, 13, 11, 9 are not writable and read 1
// - pin 3: 00 gpio, 01 chip select 7, 10 wait input, reset 10
// - pin 2: 00 gpio, 01 chip select 6, 10 timer0 capture/compare B, reset 01
// - pin 1: 00 gpio, 01 chip select 5, 10 row strobe, reset 01
// - pin 0: 00 gpio, 01 chip select 4, 10 timer0 capture/compare A, reset 01
// - gpio pin is input when its direction bit is 0, output when 1
// - data writes stored; reads give pin level if direction 0, stored value if 1
module pafs_pin_function_select
  import pafs_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        sys_rst_in,
  input  wire logic        bus_sel_in,
  input  wire logic        bus_wr_in,
  input  wire logic [27:0] bus_addr_in,
  input  wire logic [1:0]  bus_be_in,
  input  wire logic [15:0] bus_wdata_in,
  output logic      [15:0] bus_rdata_out,
  output logic             bus_ack_out,
  input  wire logic [15:0] pin_in,
  output logic      [15:0] pin_out,
  output logic      [15:0] pin_oe_n_out,
  input  wire logic        dma_acknowledge_out_1_in,
  input  wire logic        dma_acknowledge_out_0_in,
  input  wire logic        parity_upper_io_in,
  input  wire logic        parity_upper_io_drive_in,
  input  wire logic        parity_lower_io_in,
  input  wire logic        parity_lower_io_drive_in,
  input  wire logic        timer1_capcmp_b_in,
  input  wire logic        timer1_capcmp_b_drive_in,
  input  wire logic        timer1_capcmp_a_in,
  input  wire logic        timer1_capcmp_a_drive_in,
  input  wire logic        timer0_capcmp_b_in,
  input  wire logic        timer0_capcmp_b_drive_in,
  input  wire logic        timer0_capcmp_a_in,
  input  wire logic        timer0_capcmp_a_drive_in,
  input  wire logic        address_hold_out_in,
  input  wire logic        interrupt_request_out_in,
  input  wire logic        bus_grant_ack_in,
  input  wire logic        read_strobe_in,
  input  wire logic        upper_store_strobe_in,
  input  wire logic        lower_store_strobe_in,
  input  wire logic        chip_select_out_7_in,
  input  wire logic        chip_select_out_6_in,
  input  wire logic        chip_select_out_5_in,
  input  wire logic        chip_select_out_4_in,
  input  wire logic        row_strobe_in,
  output logic      [3:0]  ext_int_in_out,
  output logic      [1:0]  dma_request_in_out,
  output logic             timer_ext_clock_b_out,
  output logic             timer_ext_clock_a_out,
  output logic             parity_upper_io_out,
  output logic             parity_lower_io_out,
  output logic             timer1_capcmp_b_out,
  output logic             timer1_capcmp_a_out,
  output logic             timer0_capcmp_b_out,
  output logic             timer0_capcmp_a_out,
  output logic             conversion_trigger_in_out,
  output logic             wait_in_out
);

  pafs_state_t r;
  pafs_state_t r_nxt;
  logic [15:0] pin_lvl;
  logic [15:0] alt_on;
  logic [15:0] alt_val;
  logic [15:0] alt_drv;
  pafs_mode_t  m15, m14, m13, m12, m11, m10, m9, m3, m2, m1, m0;
  logic        hit_data, hit_dir, hit_low, hit_high, do_wr;

  pafs_pin_sync u_sync (
    .clock_in  (clock_in),
    .sys_rst_in(sys_rst_in),
    .pin_in    (pin_in),
    .level_out (pin_lvl)
  );

  // byte-lane merge; fixed-one bits cannot be written
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wd,
                                          input logic [1:0] be, input logic [15:0] wm,
                                          input logic [15:0] fx);
    logic [15:0] lane;
    lane = {{8{be[1]}}, {8{be[0]}}} & wm;
    return (old & ~lane) | (wd & lane) | fx;
  endfunction

  assign hit_data = {bus_addr_in[27:1], 1'b0} == `PAFS_DATA_ADDR;
  assign hit_dir  = {bus_addr_in[27:1], 1'b0} == `PAFS_DIR_ADDR;
  assign hit_low  = {bus_addr_in[27:1], 1'b0} == `PAFS_LOW_ADDR;
  assign hit_high = {bus_addr_in[27:1], 1'b0} == `PAFS_HIGH_ADDR;
  assign do_wr    = bus_sel_in & bus_wr_in;

  always_comb begin
    r_nxt       = r;
    r_nxt.ack   = bus_sel_in;
    r_nxt.rdata = 16'h0000;
    if (do_wr && hit_data) begin
      r_nxt.data = merge16(r.data, bus_wdata_in, bus_be_in, 16'hFFFF, 16'h0000);
    end
    if (do_wr && hit_dir) begin
      r_nxt.dir = merge16(r.dir, bus_wdata_in, bus_be_in, 16'hFFFF, 16'h0000);
    end
    if (do_wr && hit_low) begin
      r_nxt.low_sel = merge16(r.low_sel, bus_wdata_in, bus_be_in,
                              `PAFS_LOW_WMASK, `PAFS_LOW_FIXED1);
    end
    if (do_wr && hit_high) begin
      r_nxt.high_sel = merge16(r.high_sel, bus_wdata_in, bus_be_in,
                               `PAFS_HIGH_WMASK, `PAFS_HIGH_FIXED1);
    end
    if (bus_sel_in && !bus_wr_in) begin
      if (hit_data) begin
        r_nxt.rdata = (r.dir & r.data) | (~r.dir & pin_lvl);
      end else if (hit_dir) begin
        r_nxt.rdata = r.dir;
      end else if (hit_low) begin
        r_nxt.rdata = r.low_sel | `PAFS_LOW_FIXED1;
      end else if (hit_high) begin
        r_nxt.rdata = r.high_sel | `PAFS_HIGH_FIXED1;
      end
    end

    // mux decodes from the next register values so the pins follow at the write edge
    m15 = pafs_mode_t'(r_nxt.high_sel[`PAFS_P15_LSB +: 2]);
    m14 = pafs_mode_t'(r_nxt.high_sel[`PAFS_P14_LSB +: 2]);
    m13 = pafs_mode_t'(r_nxt.high_sel[`PAFS_P13_LSB +: 2]);
    m12 = pafs_mode_t'(r_nxt.high_sel[`PAFS_P12_LSB +: 2]);
    m11 = pafs_mode_t'(r_nxt.high_sel[`PAFS_P11_LSB +: 2]);
    m10 = pafs_mode_t'(r_nxt.high_sel[`PAFS_P10_LSB +: 2]);
    m9  = pafs_mode_t'(r_nxt.high_sel[`PAFS_P9_LSB +: 2]);
    m3  = pafs_mode_t'(r_nxt.low_sel[`PAFS_P3_LSB +: 2]);
    m2  = pafs_mode_t'(r_nxt.low_sel[`PAFS_P2_LSB +: 2]);
    m1  = pafs_mode_t'(r_nxt.low_sel[`PAFS_P1_LSB +: 2]);
    m0  = pafs_mode_t'(r_nxt.low_sel[`PAFS_P0_LSB +: 2]);
    alt_on  = 16'h0000;
    alt_val = 16'h0000;
    alt_drv = 16'h0000;
    // reserved codes fall to the default branch and leave the pin as gpio
    case (m15)
      PAFS_MODE_ALT1, PAFS_MODE_ALT3: alt_on[15] = 1'b1;
      default: ;
    endcase
    case (m14)
      PAFS_MODE_ALT1: alt_on[14] = 1'b1;
      PAFS_MODE_ALT3: begin
        alt_on[14]  = 1'b1;
        alt_val[14] = dma_acknowledge_out_1_in;
        alt_drv[14] = 1'b1;
      end
      default: ;
    endcase
    case (m13)
      PAFS_MODE_ALT1, PAFS_MODE_ALT2, PAFS_MODE_ALT3: alt_on[13] = 1'b1;
      default: ;
    endcase
    case (m12)
      PAFS_MODE_ALT1, PAFS_MODE_ALT2: alt_on[12] = 1'b1;
      PAFS_MODE_ALT3: begin
        alt_on[12]  = 1'b1;
        alt_val[12] = dma_acknowledge_out_0_in;
        alt_drv[12] = 1'b1;
      end
      default: ;
    endcase
    case (m11)
      PAFS_MODE_ALT1: begin
        alt_on[11]  = 1'b1;
        alt_val[11] = parity_upper_io_in;
        alt_drv[11] = parity_upper_io_drive_in;
      end
      PAFS_MODE_ALT2: begin
        alt_on[11]  = 1'b1;
        alt_val[11] = timer1_capcmp_b_in;
        alt_drv[11] = timer1_capcmp_b_drive_in;
      end
      default: ;
    endcase
    case (m10)
      PAFS_MODE_ALT1: begin
        alt_on[10]  = 1'b1;
        alt_val[10] = parity_lower_io_in;
        alt_drv[10] = parity_lower_io_drive_in;
      end
      PAFS_MODE_ALT2: begin
        alt_on[10]  = 1'b1;
        alt_val[10] = timer1_capcmp_a_in;
        alt_drv[10] = timer1_capcmp_a_drive_in;
      end
      default: ;
    endcase
    case (m9)
      PAFS_MODE_ALT1: begin
        alt_on[9]  = 1'b1;
        alt_val[9] = address_hold_out_in;
        alt_drv[9] = 1'b1;
      end
      PAFS_MODE_ALT2: alt_on[9] = 1'b1;
      PAFS_MODE_ALT3: begin
        alt_on[9]  = 1'b1;
        alt_val[9] = interrupt_request_out_in;
        alt_drv[9] = 1'b1;
      end
      default: ;
    endcase
    // pin 8 has no alternate function defined here; both values act as gpio
    alt_on[7]  = r_nxt.low_sel[`PAFS_P7_BIT];
    alt_val[7] = bus_grant_ack_in;
    alt_drv[7] = alt_on[7];
    alt_on[6]  = r_nxt.low_sel[`PAFS_P6_BIT];
    alt_val[6] = read_strobe_in;
    alt_drv[6] = alt_on[6];
    alt_on[5]  = r_nxt.low_sel[`PAFS_P5_BIT];
    alt_val[5] = upper_store_strobe_in;
    alt_drv[5] = alt_on[5];
    alt_on[4]  = r_nxt.low_sel[`PAFS_P4_BIT];
    alt_val[4] = lower_store_strobe_in;
    alt_drv[4] = alt_on[4];
    case (m3)
      PAFS_MODE_ALT1: begin
        alt_on[3]  = 1'b1;
        alt_val[3] = chip_select_out_7_in;
        alt_drv[3] = 1'b1;
      end
      PAFS_MODE_ALT2: alt_on[3] = 1'b1;
      default: ;
    endcase
    case (m2)
      PAFS_MODE_ALT1: begin
        alt_on[2]  = 1'b1;
        alt_val[2] = chip_select_out_6_in;
        alt_drv[2] = 1'b1;
      end
      PAFS_MODE_ALT2: begin
        alt_on[2]  = 1'b1;
        alt_val[2] = timer0_capcmp_b_in;
        alt_drv[2] = timer0_capcmp_b_drive_in;
      end
      default: ;
    endcase
    case (m1)
      PAFS_MODE_ALT1: begin
        alt_on[1]  = 1'b1;
        alt_val[1] = chip_select_out_5_in;
        alt_drv[1] = 1'b1;
      end
      PAFS_MODE_ALT2: begin
        alt_on[1]  = 1'b1;
        alt_val[1] = row_strobe_in;
        alt_drv[1] = 1'b1;
      end
      default: ;
    endcase
    case (m0)
      PAFS_MODE_ALT1: begin
        alt_on[0]  = 1'b1;
        alt_val[0] = chip_select_out_4_in;
        alt_drv[0] = 1'b1;
      end
      PAFS_MODE_ALT2: begin
        alt_on[0]  = 1'b1;
        alt_val[0] = timer0_capcmp_a_in;
        alt_drv[0] = timer0_capcmp_a_drive_in;
      end
      default: ;
    endcase

    // alternate pins ignore the data register; gpio pins follow data and direction
    r_nxt.pin_out  = (alt_on & alt_val) | (~alt_on & r_nxt.data);
    r_nxt.pin_oe_n = ~((alt_on & alt_drv) | (~alt_on & r_nxt.dir));

    // peripheral inputs see the synchronised pin only while selected, else idle high
    r_nxt.ext_int[3] = (m15 == PAFS_MODE_ALT1) ? pin_lvl[15] : 1'b1;
    r_nxt.ext_int[2] = (m14 == PAFS_MODE_ALT1) ? pin_lvl[14] : 1'b1;
    r_nxt.ext_int[1] = (m13 == PAFS_MODE_ALT1) ? pin_lvl[13] : 1'b1;
    r_nxt.ext_int[0] = (m12 == PAFS_MODE_ALT1) ? pin_lvl[12] : 1'b1;
    r_nxt.dma_req[1] = (m15 == PAFS_MODE_ALT3) ? pin_lvl[15] : 1'b1;
    r_nxt.dma_req[0] = (m13 == PAFS_MODE_ALT3) ? pin_lvl[13] : 1'b1;
    r_nxt.tclk[1]    = (m13 == PAFS_MODE_ALT2) ? pin_lvl[13] : 1'b1;
    r_nxt.tclk[0]    = (m12 == PAFS_MODE_ALT2) ? pin_lvl[12] : 1'b1;
    r_nxt.parity[1]  = (m11 == PAFS_MODE_ALT1) ? pin_lvl[11] : 1'b1;
    r_nxt.parity[0]  = (m10 == PAFS_MODE_ALT1) ? pin_lvl[10] : 1'b1;
    r_nxt.tim_cc[3]  = (m11 == PAFS_MODE_ALT2) ? pin_lvl[11] : 1'b1;
    r_nxt.tim_cc[2]  = (m10 == PAFS_MODE_ALT2) ? pin_lvl[10] : 1'b1;
    r_nxt.tim_cc[1]  = (m2 == PAFS_MODE_ALT2) ? pin_lvl[2] : 1'b1;
    r_nxt.tim_cc[0]  = (m0 == PAFS_MODE_ALT2) ? pin_lvl[0] : 1'b1;
    r_nxt.conversion_trigger_in      = (m9 == PAFS_MODE_ALT2) ? pin_lvl[9] : 1'b1;
    r_nxt.wait_lvl   = (m3 == PAFS_MODE_ALT2) ? pin_lvl[3] : 1'b1;
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      r.data     <= `PAFS_DATA_RST;
      r.dir      <= `PAFS_DIR_RST;
      r.low_sel  <= `PAFS_LOW_RST;
      r.high_sel <= `PAFS_HIGH_RST;
      r.pin_out  <= 16'h0000;
      r.pin_oe_n <= 16'hFFFF;
      r.rdata    <= 16'h0000;
      r.ack      <= 1'b0;
      r.ext_int  <= 4'hF;
      r.dma_req  <= 2'h3;
      r.tclk     <= 2'h3;
      r.parity   <= 2'h3;
      r.tim_cc   <= 4'hF;
      r.conversion_trigger_in    <= 1'b1;
      r.wait_lvl <= 1'b1;
    end else begin
      r <= r_nxt;
    end
  end

  assign bus_rdata_out             = r.rdata;
  assign bus_ack_out               = r.ack;
  assign pin_out                   = r.pin_out;
  assign pin_oe_n_out              = r.pin_oe_n;
  assign ext_int_in_out            = r.ext_int;
  assign dma_request_in_out        = r.dma_req;
  assign timer_ext_clock_b_out     = r.tclk[1];
  assign timer_ext_clock_a_out     = r.tclk[0];
  assign parity_upper_io_out       = r.parity[1];
  assign parity_lower_io_out       = r.parity[0];
  assign timer1_capcmp_b_out       = r.tim_cc[3];
  assign timer1_capcmp_a_out       = r.tim_cc[2];
  assign timer0_capcmp_b_out       = r.tim_cc[1];
  assign timer0_capcmp_a_out       = r.tim_cc[0];
  assign conversion_trigger_in_out = r.conversion_trigger_in;
  assign wait_in_out               = r.wait_lvl;

endmodule // pafs_pin_function_select

// >>> verif/pafs_fs_props.sv
// pafs_fs_props: bus and pin-mux relations of the port A select block
// assumes: bound to pafs_pin_function_select, sees its ports only
`timescale 1ns/1ps
`include "pafs_defs.svh"
module pafs_fs_props (
  input wire logic        clock_in,
  input wire logic        sys_rst_in,
  input wire logic        bus_sel_in,
  input wire logic        bus_wr_in,
  input wire logic [27:0] bus_addr_in,
  input wire logic [1:0]  bus_be_in,
  input wire logic [15:0] bus_wdata_in,
  input wire logic [15:0] bus_rdata_out,
  input wire logic        bus_ack_out,
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe_n_out,
  input wire logic        chip_select_out_4_in,
  input wire logic        dma_acknowledge_out_1_in,
  input wire logic        wait_in_out
);
  logic [15:0] lo_r;
  logic [15:0] hi_r;
  logic        live_r;
  wire  [15:0] lane = {{8{bus_be_in[1]}}, {8{bus_be_in[0]}}};
  wire  [15:0] lo_m = lane & `PAFS_LOW_WMASK;
  wire  [15:0] hi_m = lane & `PAFS_HIGH_WMASK;
  wire  [27:0] hw_addr = {bus_addr_in[27:1], 1'h0};
  wire         wr_go = bus_sel_in && bus_wr_in;
  // shadow of the mode registers as written over the bus
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      lo_r   <= `PAFS_LOW_RST;
      hi_r   <= `PAFS_HIGH_RST;
      live_r <= 1'h0;
    end else begin
      live_r <= 1'h1;
      if (wr_go && hw_addr == `PAFS_LOW_ADDR) lo_r <= (lo_r & ~lo_m) | (bus_wdata_in & lo_m);
      if (wr_go && hw_addr == `PAFS_HIGH_ADDR) hi_r <= (hi_r & ~hi_m) | (bus_wdata_in & hi_m);
    end
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_read(logic [27:0] a);
    bus_sel_in && !bus_wr_in && hw_addr == a;
  endsequence
  sequence s_no_wait;
    lo_r[7:6] != 2'h2;
  endsequence
  a_ack_follows: assert property (bus_sel_in |=> bus_ack_out)
    else $error("no ack after request");
  a_ack_single: assert property (!bus_sel_in |=> !bus_ack_out)
    else $error("ack without request");
  a_low_readback: assert property (s_read(`PAFS_LOW_ADDR) |=> bus_rdata_out == lo_r)
    else $error("low select readback");
  a_high_readback: assert property (s_read(`PAFS_HIGH_ADDR) |=> bus_rdata_out == hi_r)
    else $error("high select readback");
  a_pin0_cs_route: assert property (live_r && lo_r[1:0] == 2'h1 |->
    !pin_oe_n_out[0] && pin_out[0] == $past(chip_select_out_4_in)) else $error("pin 0 select route");
  a_pin14_dack: assert property (live_r && hi_r[13:12] == 2'h3 |->
    !pin_oe_n_out[14] && pin_out[14] == $past(dma_acknowledge_out_1_in)) else $error("pin 14 route");
  a_pin3_released: assert property (live_r && lo_r[7:6] == 2'h2 |-> pin_oe_n_out[3])
    else $error("pin 3 driven in wait mode");
  a_wait_idle: assert property (s_no_wait [*2] |-> wait_in_out)
    else $error("wait input not idle");
endmodule // pafs_fs_props

bind pafs_pin_function_select pafs_fs_props u_fs_props (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
  .bus_sel_in(bus_sel_in), .bus_wr_in(bus_wr_in), .bus_addr_in(bus_addr_in), .bus_be_in(bus_be_in),
  .bus_wdata_in(bus_wdata_in), .bus_rdata_out(bus_rdata_out), .bus_ack_out(bus_ack_out), .pin_out(pin_out),
  .pin_oe_n_out(pin_oe_n_out), .chip_select_out_4_in(chip_select_out_4_in),
  .dma_acknowledge_out_1_in(dma_acknowledge_out_1_in), .wait_in_out(wait_in_out));

// >>> verif/pafs_pin_model.sv
// pafs_pin_model: the port A pins as wires shared with outside parties
// assumes: block drive wins; bench drives where enabled
`timescale 1ns/1ps
module pafs_pin_model (
  input  wire logic        clock_in,
  input  wire logic [15:0] pin_out_in,
  input  wire logic [15:0] pin_oe_n_in,
  input  wire logic [15:0] drv_in,
  input  wire logic [15:0] drv_en_in,
  output logic      [15:0] level_out
);
  logic [15:0] last_r = 16'h0;
  // a released pin has no pull, so it shows a value that changes every cycle
  always_ff @(posedge clock_in) last_r <= level_out;
  always_comb level_out = (pin_out_in & ~pin_oe_n_in) | (pin_oe_n_in & ((drv_in & drv_en_in) | (~last_r & ~drv_en_in)));
endmodule // pafs_pin_model

// >>> verif/testbench.sv
// testbench: registers, pin multiplexer and pin inputs of the port A select block
// assumes: design, pin model and checker compiled first
`timescale 1ns/1ps
`include "pafs_defs.svh"
module testbench;
  logic        clock_in = 1'h0;
  logic        sys_rst_in = 1'h1;
  logic        sel = 1'h0;
  logic        wr = 1'h0;
  logic [27:0] addr = 28'h0;
  logic [1:0]  be = 2'h0;
  logic [15:0] wd = 16'h0;
  logic [15:0] drv = 16'h0;
  logic [15:0] en = 16'h0;
  logic [24:0] per = 25'h0;
  logic [15:0] q;
  wire  [15:0] rdata, pout, poe_n, lvl;
  wire  [3:0]  ext;
  wire  [1:0]  dreq;
  wire         ack, tcb, tca, adt, wt;
  wire  [5:0]  cc;
  int          bad_count = 0;
  int          n_compared = 0;

  always #5 clock_in = ~clock_in;

  pafs_pin_function_select DUT (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .bus_sel_in(sel), .bus_wr_in(wr),
    .bus_addr_in(addr), .bus_be_in(be), .bus_wdata_in(wd), .bus_rdata_out(rdata), .bus_ack_out(ack),
    .pin_in(lvl), .pin_out(pout), .pin_oe_n_out(poe_n),
    .dma_acknowledge_out_1_in(per[0]), .dma_acknowledge_out_0_in(per[1]), .parity_upper_io_in(per[2]),
    .parity_upper_io_drive_in(per[3]), .parity_lower_io_in(per[4]), .parity_lower_io_drive_in(per[5]),
    .timer1_capcmp_b_in(per[6]), .timer1_capcmp_b_drive_in(per[7]), .timer1_capcmp_a_in(per[8]),
    .timer1_capcmp_a_drive_in(per[9]), .timer0_capcmp_b_in(per[10]), .timer0_capcmp_b_drive_in(per[11]),
    .timer0_capcmp_a_in(per[12]), .timer0_capcmp_a_drive_in(per[13]), .address_hold_out_in(per[14]),
    .interrupt_request_out_in(per[15]), .bus_grant_ack_in(per[16]), .read_strobe_in(per[17]),
    .upper_store_strobe_in(per[18]), .lower_store_strobe_in(per[19]), .chip_select_out_7_in(per[20]),
    .chip_select_out_6_in(per[21]), .chip_select_out_5_in(per[22]), .chip_select_out_4_in(per[23]),
    .row_strobe_in(per[24]), .ext_int_in_out(ext), .dma_request_in_out(dreq), .timer_ext_clock_b_out(tcb),
    .timer_ext_clock_a_out(tca), .parity_upper_io_out(cc[5]), .parity_lower_io_out(cc[4]),
    .timer1_capcmp_b_out(cc[3]), .timer1_capcmp_a_out(cc[2]), .timer0_capcmp_b_out(cc[1]),
    .timer0_capcmp_a_out(cc[0]),
    .conversion_trigger_in_out(adt), .wait_in_out(wt));
  pafs_pin_model u_pins (.clock_in(clock_in), .pin_out_in(pout), .pin_oe_n_in(poe_n), .drv_in(drv),
    .drv_en_in(en), .level_out(lvl));

  task automatic tally_and_finish;
    if (bad_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic cmp(input logic [15:0] g, input logic [15:0] x, input string m);
    n_compared++;
    if (g !== x) begin
      bad_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, x);
    end
  endtask

  task automatic bus(input logic w, input logic [27:0] a, input logic [1:0] b, input logic [15:0] d);
    int i;
    @(negedge clock_in);
    {sel, wr, addr, be, wd} = {1'h1, w, a, b, d};
    for (i = 0; i < 4; i++) begin
      @(negedge clock_in);
      if (ack === 1'h1) break;
    end
    q = rdata;
    @(negedge clock_in);
    sel = 1'h0;
    if (i == 4) begin
      bad_count++;
      $display("MISMATCH t=%0t no ack", $time);
      tally_and_finish();
    end
  endtask

  task automatic rd_cmp(input logic [27:0] a, input logic [15:0] x, input string m);
    bus(1'h0, a, 2'h3, 16'h0);
    cmp(q, x, m);
  endtask

  // expected {drive enables, drive values} of the sixteen pins
  function automatic logic [31:0] ref_pins(input logic [15:0] lo, hi, dir, dat, input logic [24:0] p);
    logic [15:0] o, e;
    o = dat;
    e = dir;
    if (hi[14]) e[15] = 1'h0;
    if (hi[13:12] == 2'h1) e[14] = 1'h0;
    if (hi[13:12] == 2'h3) {e[14], o[14]} = {1'h1, p[0]};
    if (hi[11:10] != 2'h0) e[13] = 1'h0;
    if (^hi[9:8]) e[12] = 1'h0;
    if (hi[9:8] == 2'h3) {e[12], o[12]} = {1'h1, p[1]};
    if (hi[6]) {e[11], o[11]} = p[3:2];
    if (hi[7]) {e[11], o[11]} = p[7:6];
    if (hi[4]) {e[10], o[10]} = p[5:4];
    if (hi[5]) {e[10], o[10]} = p[9:8];
    if (hi[3:2] == 2'h1) {e[9], o[9]} = {1'h1, p[14]};
    if (hi[3:2] == 2'h2) e[9] = 1'h0;
    if (hi[3:2] == 2'h3) {e[9], o[9]} = {1'h1, p[15]};
    if (lo[14]) {e[7], o[7]} = {1'h1, p[16]};
    if (lo[12]) {e[6], o[6]} = {1'h1, p[17]};
    if (lo[10]) {e[5], o[5]} = {1'h1, p[18]};
    if (lo[8]) {e[4], o[4]} = {1'h1, p[19]};
    if (lo[6]) {e[3], o[3]} = {1'h1, p[20]};
    if (lo[7]) e[3] = 1'h0;
    if (lo[4]) {e[2], o[2]} = {1'h1, p[21]};
    if (lo[5]) {e[2], o[2]} = p[11:10];
    if (lo[2]) {e[1], o[1]} = {1'h1, p[22]};
    if (lo[3]) {e[1], o[1]} = {1'h1, p[24]};
    if (lo[0]) {e[0], o[0]} = {1'h1, p[23]};
    if (lo[1]) {e[0], o[0]} = p[13:12];
    return {e, o};
  endfunction

  // expected {parity[1:0], capcmp[3:0], ext_int[3:0], dreq[1:0], tclk b, tclk a, trigger, wait}
  function automatic logic [15:0] ref_ins(input logic [15:0] lo, hi, v);
    logic [15:0] r;
    r = 16'hFFFF;
    if (hi[6]) r[15] = v[11];
    if (hi[4]) r[14] = v[10];
    if (hi[7]) r[13] = v[11];
    if (hi[5]) r[12] = v[10];
    if (lo[5]) r[11] = v[2];
    if (lo[1]) r[10] = v[0];
    if (hi[15:14] == 2'h1) r[9] = v[15];
    if (hi[13:12] == 2'h1) r[8] = v[14];
    if (hi[11:10] == 2'h1) r[7] = v[13];
    if (hi[9:8] == 2'h1) r[6] = v[12];
    if (hi[15:14] == 2'h3) r[5] = v[15];
    if (hi[11:10] == 2'h3) r[4] = v[13];
    if (hi[11:10] == 2'h2) r[3] = v[13];
    if (hi[9:8] == 2'h2) r[2] = v[12];
    if (hi[3:2] == 2'h2) r[1] = v[9];
    if (lo[7]) r[0] = v[3];
    return r;
  endfunction

  // two complementary patterns on peripheral signals and pins, then pins, inputs and registers
  task automatic check_all(input logic [15:0] lo, hi, dir, dat);
    logic [31:0] r;
    logic [15:0] lv;
    for (int k = 0; k < 2; k++) begin
      @(negedge clock_in);
      per = k ? 25'h1555555 : 25'h0AAAAAA;
      drv = k ? 16'h5A3C : 16'hA5C3;
      repeat (8) @(negedge clock_in);
      r = ref_pins(lo, hi, dir, dat, per);
      lv = (r[15:0] & r[31:16]) | (drv & ~r[31:16]);
      cmp(poe_n, ~r[31:16], "pin enables");
      cmp(pout & r[31:16], r[15:0] & r[31:16], "pin values");
      cmp({cc, ext, dreq, tcb, tca, adt, wt}, ref_ins(lo, hi, lv), "pin inputs");
      rd_cmp(`PAFS_DATA_ADDR, (lv & ~dir) | (dat & dir), "data");
    end
    rd_cmp(`PAFS_LOW_ADDR, lo, "low select");
    rd_cmp(`PAFS_HIGH_ADDR, hi, "high select");
    rd_cmp(`PAFS_DIR_ADDR, dir, "direction");
  endtask

  task automatic t_reset;
    check_all(16'hFF95, 16'h3302, 16'h0, 16'h0);
  endtask

  task automatic t_alt1;
    bus(1'h1, `PAFS_LOW_ADDR, 2'h3, 16'h0055);
    bus(1'h1, `PAFS_HIGH_ADDR, 2'h3, 16'h5555);
    check_all(16'hAA55, 16'h5557, 16'h0, 16'h0);
  endtask

  task automatic t_alt2;
    bus(1'h1, `PAFS_LOW_ADDR, 2'h3, 16'h00AA);
    bus(1'h1, `PAFS_HIGH_ADDR, 2'h3, 16'h0AA8);
    check_all(16'hAAAA, 16'h0AAA, 16'h0, 16'h0);
  endtask

  task automatic t_alt3;
    bus(1'h1, `PAFS_LOW_ADDR, 2'h3, 16'h5555);
    bus(1'h1, `PAFS_HIGH_ADDR, 2'h3, 16'hFF0C);
    check_all(16'hFF55, 16'hFF0E, 16'h0, 16'h0);
  endtask

  task automatic t_gpio;
    bus(1'h1, `PAFS_LOW_ADDR, 2'h3, 16'h0000);
    bus(1'h1, `PAFS_HIGH_ADDR, 2'h3, 16'h0000);
    bus(1'h1, `PAFS_DIR_ADDR, 2'h3, 16'h0FF0);
    bus(1'h1, `PAFS_DATA_ADDR, 2'h3, 16'h3C3C);
    bus(1'h1, `PAFS_DATA_ADDR, 2'h1, 16'h00FF);
    check_all(16'hAA00, 16'h0002, 16'h0FF0, 16'h3CFF);
    bus(1'h1, `PAFS_LOW_ADDR, 2'h2, 16'h5555);
    bus(1'h1, 28'h5FFFFC0, 2'h3, 16'hFFFF);
    rd_cmp(28'h5FFFFC0, 16'h0000, "unmapped");
    check_all(16'hFF00, 16'h0002, 16'h0FF0, 16'h3CFF);
  endtask

  task automatic t_rerun;
    @(negedge clock_in);
    sys_rst_in = 1'h1;
    repeat (2) @(negedge clock_in);
    sys_rst_in = 1'h0;
    check_all(16'hFF95, 16'h3302, 16'h0, 16'h0);
  endtask

  initial begin
    repeat (20) @(negedge clock_in);
    sys_rst_in = 1'h0;
    en = 16'hFFFF;
    t_reset();
    t_alt1();
    t_alt2();
    t_alt3();
    t_gpio();
    t_rerun();
    tally_and_finish();
  end
endmodule // testbench
